// ### logic/mode_tracker_regs.svh
`ifndef MODE_TRACKER_REGS_SVH
`define MODE_TRACKER_REGS_SVH

// Register byte offsets
`define ADR_ROOT_CTRL    8'h00
`define ADR_GUEST_CTRL   8'h04
`define ADR_ROOT_EPC     8'h08
`define ADR_ROOT_ERRPC   8'h0c
`define ADR_DEBUG_PC     8'h10
`define ADR_GUEST_EPC    8'h14
`define ADR_GUEST_ERRPC  8'h18
`define ADR_MODE         8'h1c
`define ADR_IRQ_STATUS   8'h20
`define ADR_IRQ_CLEAR    8'h24
`define ADR_IRQ_ENABLE   8'h28

// Control register fields
`define CTL_GSEL         0
`define CTL_EXL          1
`define CTL_ERL          2
`define CTL_DM           3
`define CTL_PRIV_LO      4
`define CTL_PRIV_HI      5

// One-hot mode positions
`define MODE_DBG         0
`define MODE_RK          1
`define MODE_RS          2
`define MODE_RU          3
`define MODE_GK          4
`define MODE_GS          5
`define MODE_GU          6
`define MODE_W           7

// Event bits
`define EV_GUEST_IN      0
`define EV_GUEST_OUT     1
`define EV_HYPERVISOR_CALL_INSTR       2
`define EV_DEBUG         3
`define EV_ILLEGAL       4
`define EV_W             5

// Reset values
`define RST_ERL          1'b1
`define RST_GSEL         1'b0

// Privilege field codes
`define PRIV_KERNEL      2'h0
`define PRIV_SUPER       2'h1

`endif

// ### logic/mode_tracker_pkg.sv
`include "mode_tracker_regs.svh"

package mode_tracker_pkg;

  typedef struct packed {
    logic                 gsel;
    logic                 rexl;
    logic                 rerl;
    logic                 dm;
    logic [1:0]           rpriv;
    logic                 gexl;
    logic                 gerl;
    logic [1:0]           gpriv;
    logic [31:0]          exception_return_pc;
    logic [31:0]          errpc;
    logic [31:0]          debug_return_pc;
    logic [31:0]          gepc;
    logic [31:0]          gerrpc;
    logic [`EV_W-1:0]     ist;
    logic [`EV_W-1:0]     ien;
    logic                 ack;
    logic [31:0]          rdata;
    logic                 redirect;
    logic [31:0]          target;
  } tracker_state_t;

endpackage : mode_tracker_pkg

// ### logic/mode_decode.sv
`timescale 1ns/100ps
`include "mode_tracker_regs.svh"

module mode_decode
  import mode_tracker_pkg::*;
(
  input  wire logic             dm_i,
  input  wire logic             root_erl_i,
  input  wire logic             root_exl_i,
  input  wire logic [1:0]       root_priv_i,
  input  wire logic             guest_sel_i,
  input  wire logic             guest_erl_i,
  input  wire logic             guest_exl_i,
  input  wire logic [1:0]       guest_priv_i,
  output logic      [`MODE_W-1:0] mode_o,
  output logic                  bad_priv_o
);

  // Kernel, supervisor, user; code 11 falls to user, least privilege
  function automatic logic [2:0] priv_sel(input logic [1:0] f);
    logic [2:0] r;
    r = 3'h4;
    if (f == `PRIV_KERNEL)
    begin
      r = 3'h1;
    end
    else if (f == `PRIV_SUPER)
    begin
      r = 3'h2;
    end
    return r;
  endfunction : priv_sel

  always_comb
  begin
    mode_o     = '0;
    bad_priv_o = 1'b0;
    if (dm_i)
    begin
      mode_o[`MODE_DBG] = 1'b1;
    end
    else if (root_erl_i || root_exl_i)
    begin
      mode_o[`MODE_RK] = 1'b1;
    end
    else if (!guest_sel_i)
    begin
      mode_o[`MODE_RU:`MODE_RK] = priv_sel(root_priv_i);
      bad_priv_o                = &root_priv_i;
    end
    else if (guest_erl_i || guest_exl_i)
    begin
      mode_o[`MODE_GK] = 1'b1;
    end
    else
    begin
      mode_o[`MODE_GU:`MODE_GK] = priv_sel(guest_priv_i);
      bad_priv_o                = &guest_priv_i;
    end
  end

endmodule : mode_decode

// ### logic/guest_root_mode_tracker.sv
// Behaviour
// - Guest mode only with guest-select 1 and root exception, error, debug all 0.
// - Root mode when debug bit clear and guest-select 0 or any root level set.
// - Root exception return with error level 0 targets exception PC, clears exception level.
// - After that return, core is in guest mode if guest-select was set.
// - Exception and debug returns use their return PCs exactly as the base core.
// - Root exception entry sets root exception or error level; handler runs in root.
// - Hypervisor call in guest mode raises exception handled in root mode.
// - Exception return in guest mode never switches to root mode.
// - Guest software cannot modify root control, status or debug state.
// - Guest sub-mode from guest levels and privilege field; field 11 unpredictable.
// - Guest exception entry leaves root levels untouched; handler runs in guest.
// - Reset sets root error level so execution starts in root mode.
// - Reset clears guest-select bit.
// - Debug flag set means debug mode, overriding every other bit.
// - Debug, root and guest modes are mutually exclusive.
// - Root kernel from levels; else root privilege field picks kernel, supervisor, user.
`timescale 1ns/100ps
`include "mode_tracker_regs.svh"

module guest_root_mode_tracker
  import mode_tracker_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               exception_return_instr_i,
  input  wire logic               debug_return_instr_i,
  input  wire logic               hypervisor_call_instr_i,
  input  wire logic               exc_take_i,
  input  wire logic               exc_error_i,
  input  wire logic               exc_root_i,
  input  wire logic               dbg_take_i,
  input  wire logic [31:0]        pc_i,
  output logic                    redirect_o,
  output logic      [31:0]        target_o,
  output logic      [`MODE_W-1:0] mode_o,
  output logic                    guest_mode_o,
  output logic                    root_mode_o,
  output logic                    debug_mode_o,
  output logic                    bad_priv_o,
  output logic                    irq_o
);

  tracker_state_t     s_r;
  tracker_state_t     s_nxt;
  logic [`MODE_W-1:0] mode;
  logic               bad_priv;
  logic               bus_req;
  logic               bus_wr;
  logic [`EV_W-1:0]   ev;
  logic [`EV_W-1:0]   clr;

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : byte_merge

  function automatic logic [31:0] ctrl_word(input logic       gsel,
                                            input logic       exception_level_bit,
                                            input logic       error_level_bit,
                                            input logic       dm,
                                            input logic [1:0] priv);
    logic [31:0] r;
    r                                = '0;
    r[`CTL_GSEL]                     = gsel;
    r[`CTL_EXL]                      = exception_level_bit;
    r[`CTL_ERL]                      = error_level_bit;
    r[`CTL_DM]                       = dm;
    r[`CTL_PRIV_HI:`CTL_PRIV_LO]     = priv;
    return r;
  endfunction : ctrl_word

  mode_decode u_decode (
    .dm_i         (s_r.dm),
    .root_erl_i   (s_r.rerl),
    .root_exl_i   (s_r.rexl),
    .root_priv_i  (s_r.rpriv),
    .guest_sel_i  (s_r.gsel),
    .guest_erl_i  (s_r.gerl),
    .guest_exl_i  (s_r.gexl),
    .guest_priv_i (s_r.gpriv),
    .mode_o       (mode),
    .bad_priv_o   (bad_priv)
  );

  assign mode_o       = mode;
  assign bad_priv_o   = bad_priv;
  assign debug_mode_o = mode[`MODE_DBG];
  // root covers the three root sub-modes
  assign root_mode_o  = mode[`MODE_RK] | mode[`MODE_RS] | mode[`MODE_RU];
  // guest covers the three guest sub-modes
  assign guest_mode_o = mode[`MODE_GK] | mode[`MODE_GS] | mode[`MODE_GU];
  assign wb_ack_o     = s_r.ack;
  assign wb_dat_o     = s_r.rdata;
  assign redirect_o   = s_r.redirect;
  assign target_o     = s_r.target;
  assign irq_o        = |(s_r.ist & s_r.ien);
  assign bus_req      = wb_cyc_i & wb_stb_i & ~s_r.ack;
  assign bus_wr       = bus_req & wb_we_i;

  always_comb
  begin
    s_nxt          = s_r;
    ev             = '0;
    clr            = '0;
    s_nxt.ack      = bus_req;
    s_nxt.redirect = 1'b0;
    if (bus_req)
    begin
      unique case (wb_adr_i)
        `ADR_ROOT_CTRL:   s_nxt.rdata = ctrl_word(s_r.gsel, s_r.rexl, s_r.rerl, s_r.dm, s_r.rpriv);
        `ADR_GUEST_CTRL:  s_nxt.rdata = ctrl_word(1'b0, s_r.gexl, s_r.gerl, 1'b0, s_r.gpriv);
        `ADR_ROOT_EPC:    s_nxt.rdata = s_r.exception_return_pc;
        `ADR_ROOT_ERRPC:  s_nxt.rdata = s_r.errpc;
        `ADR_DEBUG_PC:    s_nxt.rdata = s_r.debug_return_pc;
        `ADR_GUEST_EPC:   s_nxt.rdata = s_r.gepc;
        `ADR_GUEST_ERRPC: s_nxt.rdata = s_r.gerrpc;
        `ADR_MODE:        s_nxt.rdata = {{(32-`MODE_W){1'b0}}, mode};
        `ADR_IRQ_STATUS:  s_nxt.rdata = {{(32-`EV_W){1'b0}}, s_r.ist};
        `ADR_IRQ_ENABLE:  s_nxt.rdata = {{(32-`EV_W){1'b0}}, s_r.ien};
        default:          s_nxt.rdata = '0;
      endcase
    end
    if (bus_wr)
    begin
      unique case (wb_adr_i)
        `ADR_ROOT_CTRL:
        begin
          if (guest_mode_o)
          begin
            ev[`EV_ILLEGAL] = 1'b1;
          end
          else if (wb_sel_i[0])
          begin
            s_nxt.gsel  = wb_dat_i[`CTL_GSEL];
            s_nxt.rexl  = wb_dat_i[`CTL_EXL];
            s_nxt.rerl  = wb_dat_i[`CTL_ERL];
            s_nxt.rpriv = wb_dat_i[`CTL_PRIV_HI:`CTL_PRIV_LO];
          end
        end
        `ADR_GUEST_CTRL:
        begin
          if (wb_sel_i[0])
          begin
            s_nxt.gexl  = wb_dat_i[`CTL_EXL];
            s_nxt.gerl  = wb_dat_i[`CTL_ERL];
            s_nxt.gpriv = wb_dat_i[`CTL_PRIV_HI:`CTL_PRIV_LO];
          end
        end
        `ADR_ROOT_EPC,
        `ADR_ROOT_ERRPC,
        `ADR_DEBUG_PC:
        begin
          // root return PCs locked from guest
          if (guest_mode_o)
          begin
            ev[`EV_ILLEGAL] = 1'b1;
          end
          else if (wb_adr_i == `ADR_ROOT_EPC)
          begin
            s_nxt.exception_return_pc = byte_merge(s_r.exception_return_pc, wb_dat_i, wb_sel_i);
          end
          else if (wb_adr_i == `ADR_ROOT_ERRPC)
          begin
            s_nxt.errpc = byte_merge(s_r.errpc, wb_dat_i, wb_sel_i);
          end
          else
          begin
            s_nxt.debug_return_pc = byte_merge(s_r.debug_return_pc, wb_dat_i, wb_sel_i);
          end
        end
        `ADR_GUEST_EPC:   s_nxt.gepc   = byte_merge(s_r.gepc, wb_dat_i, wb_sel_i);
        `ADR_GUEST_ERRPC: s_nxt.gerrpc = byte_merge(s_r.gerrpc, wb_dat_i, wb_sel_i);
        `ADR_IRQ_CLEAR:   clr          = wb_sel_i[0] ? wb_dat_i[`EV_W-1:0] : '0;
        `ADR_IRQ_ENABLE:  s_nxt.ien    = wb_sel_i[0] ? wb_dat_i[`EV_W-1:0] : s_r.ien;
        default:          s_nxt.rdata  = s_nxt.rdata;
      endcase
    end
    // Core events win over a bus write in the same cycle
    if (dbg_take_i)
    begin
      s_nxt.dm       = 1'b1;
      s_nxt.debug_return_pc     = pc_i;
      ev[`EV_DEBUG]  = 1'b1;
    end
    else if (exc_take_i)
    begin
      if (guest_mode_o && !exc_root_i)
      begin
        if (exc_error_i)
        begin
          s_nxt.gerl   = 1'b1;
          s_nxt.gerrpc = pc_i;
        end
        else
        begin
          s_nxt.gexl = 1'b1;
          s_nxt.gepc = s_r.gexl ? s_r.gepc : pc_i;
        end
      end
      // root exception sets a root level
      else
      begin
        if (exc_error_i)
        begin
          s_nxt.rerl  = 1'b1;
          s_nxt.errpc = pc_i;
        end
        else
        begin
          s_nxt.rexl = 1'b1;
          s_nxt.exception_return_pc  = s_r.rexl ? s_r.exception_return_pc : pc_i;
        end
        ev[`EV_GUEST_OUT] = guest_mode_o;
      end
    end
    else if (hypervisor_call_instr_i && guest_mode_o)
    begin
      s_nxt.rexl        = 1'b1;
      s_nxt.exception_return_pc         = pc_i;
      ev[`EV_HYPERVISOR_CALL_INSTR]   = 1'b1;
      ev[`EV_GUEST_OUT] = 1'b1;
    end
    else if (debug_return_instr_i && debug_mode_o)
    begin
      s_nxt.dm       = 1'b0;
      s_nxt.target   = s_r.debug_return_pc;
      s_nxt.redirect = 1'b1;
    end
    else if (exception_return_instr_i && !debug_mode_o)
    begin
      s_nxt.redirect = 1'b1;
      // guest return touches guest context only
      if (guest_mode_o)
      begin
        if (s_r.gerl)
        begin
          s_nxt.gerl   = 1'b0;
          s_nxt.target = s_r.gerrpc;
        end
        else
        begin
          s_nxt.gexl   = 1'b0;
          s_nxt.target = s_r.gepc;
        end
      end
      else if (s_r.rerl)
      begin
        s_nxt.rerl   = 1'b0;
        s_nxt.target = s_r.errpc;
      end
      else
      begin
        s_nxt.rexl         = 1'b0;
        s_nxt.target       = s_r.exception_return_pc;
        ev[`EV_GUEST_IN]   = s_nxt.gsel;
      end
    end
    ev[`EV_ILLEGAL] = ev[`EV_ILLEGAL] | bad_priv;
    // Set wins over clear
    s_nxt.ist = (s_r.ist & ~clr) | ev;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r      <= '0;
      // start in root via error level
      s_r.rerl <= `RST_ERL;
      s_r.gsel <= `RST_GSEL;
    end
    else if (ce_i)
    begin
      s_r <= s_nxt;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_guest_definition: assert property (
    guest_mode_o == (s_r.gsel && !s_r.rexl && !s_r.rerl && !s_r.dm))
    else $error("guest mode does not match control bits");

  a_root_definition: assert property (
    root_mode_o == (!s_r.dm && (!s_r.gsel || s_r.rerl || s_r.rexl)))
    else $error("root mode does not match control bits");

  a_exception_return_instr_target: assert property (
    ce_i && exception_return_instr_i && root_mode_o && !s_r.rerl && !dbg_take_i && !exc_take_i
    |=> !s_r.rexl && redirect_o && target_o == $past(s_r.exception_return_pc))
    else $error("root exception return wrong target or level");

  a_exception_return_instr_guest_entry: assert property (
    ce_i && exception_return_instr_i && root_mode_o && !s_r.rerl && s_r.gsel && !dbg_take_i && !exc_take_i && !bus_wr
    |=> guest_mode_o ##0 s_r.ist[`EV_GUEST_IN])
    else $error("exception return with select set did not enter guest");

  a_guest_exception_return_instr_stay: assert property (
    ce_i && exception_return_instr_i && guest_mode_o && !dbg_take_i && !exc_take_i && !hypervisor_call_instr_i
    |=> guest_mode_o && redirect_o)
    else $error("guest exception return left guest mode");

  a_root_exc_entry: assert property (
    ce_i && exc_take_i && !dbg_take_i && !s_r.dm && (root_mode_o || exc_root_i)
    |=> root_mode_o && (s_r.rexl || s_r.rerl))
    else $error("root exception did not set a root level");

  a_hypervisor_call_instr_exit: assert property (
    ce_i && hypervisor_call_instr_i && guest_mode_o && !dbg_take_i && !exc_take_i
    |=> root_mode_o && s_r.ist[`EV_HYPERVISOR_CALL_INSTR] && s_r.exception_return_pc == $past(pc_i))
    else $error("hypervisor call did not reach root mode");

  a_guest_exc_keep: assert property (
    ce_i && exc_take_i && guest_mode_o && !exc_root_i && !dbg_take_i
    |=> $stable(s_r.rexl) && $stable(s_r.rerl) && guest_mode_o)
    else $error("guest exception changed root levels");

  a_guest_write_lock: assert property (
    ce_i && bus_wr && wb_adr_i == `ADR_ROOT_CTRL && guest_mode_o && !dbg_take_i && !exc_take_i && !hypervisor_call_instr_i
    |=> $stable(s_r.gsel) && $stable(s_r.rpriv) && s_r.ist[`EV_ILLEGAL])
    else $error("guest write altered root control");

  a_reset_error_level: assert property (
    $past(rst_i) |-> s_r.rerl && root_mode_o)
    else $error("reset did not start in root mode");

  a_reset_select_clear: assert property (
    $past(rst_i) |-> !s_r.gsel)
    else $error("reset did not clear guest select");

  a_debug_override: assert property (
    s_r.dm |-> mode_o[`MODE_DBG] && !root_mode_o && !guest_mode_o)
    else $error("debug flag did not force debug mode");

  a_mode_exclusive: assert property (
    $onehot(mode_o))
    else $error("mode output not one-hot");

endmodule : guest_root_mode_tracker

// ### verification/testbench.sv
`timescale 1ns/100ps
`include "mode_tracker_regs.svh"

module testbench
  import mode_tracker_pkg::*;
;
  logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, pc_i = 32'h0, wb_dat_o, target_o;
  logic        exception_return_instr_i = 1'b0, debug_return_instr_i = 1'b0, hypervisor_call_instr_i = 1'b0, exc_take_i = 1'b0;
  logic        exc_error_i = 1'b0, exc_root_i = 1'b0, dbg_take_i = 1'b0;
  logic        wb_ack_o, redirect_o, guest_mode_o, root_mode_o, debug_mode_o, bad_priv_o, irq_o;
  logic [6:0]  mode_o;
  // Reference model state
  logic        m_gsel = 1'b0, m_rexl = 1'b0, m_rerl = 1'b1, m_dm = 1'b0;
  logic        m_gexl = 1'b0, m_gerl = 1'b0, m_redir = 1'b0;
  logic [1:0]  m_rpriv = 2'h0, m_gpriv = 2'h0;
  logic [31:0] m_epc = 32'h0, m_errpc = 32'h0, m_debug_return_pc = 32'h0, m_gepc = 32'h0, m_gerrpc = 32'h0;
  logic [31:0] m_tgt = 32'h0, seed = 32'h59, r, q;
  logic [4:0]  m_ist = 5'h00, m_ien = 5'h00;
  int          fail_count = 0, check_count = 0;

  guest_root_mode_tracker uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .exception_return_instr_i(exception_return_instr_i), .debug_return_instr_i(debug_return_instr_i), .hypervisor_call_instr_i(hypervisor_call_instr_i),
    .exc_take_i(exc_take_i), .exc_error_i(exc_error_i), .exc_root_i(exc_root_i), .dbg_take_i(dbg_take_i),
    .pc_i(pc_i), .redirect_o(redirect_o), .target_o(target_o), .mode_o(mode_o),
    .guest_mode_o(guest_mode_o), .root_mode_o(root_mode_o), .debug_mode_o(debug_mode_o),
    .bad_priv_o(bad_priv_o), .irq_o(irq_o));

  always #2.5 clk_i = ~clk_i;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic guest();
    return m_gsel & ~m_dm & ~m_rerl & ~m_rexl;
  endfunction : guest

  function automatic logic badp();
    return !m_dm && !m_rerl && !m_rexl && (m_gsel ? !m_gerl && !m_gexl && m_gpriv == 2'h3 : m_rpriv == 2'h3);
  endfunction : badp

  function automatic logic [6:0] exp_mode();
    if (m_dm) return 7'h01;
    if (m_rerl | m_rexl) return 7'h02;
    if (!m_gsel) return (m_rpriv == 2'h0) ? 7'h02 : (m_rpriv == 2'h1) ? 7'h04 : 7'h08;
    if (m_gerl | m_gexl) return 7'h10;
    return (m_gpriv == 2'h0) ? 7'h10 : (m_gpriv == 2'h1) ? 7'h20 : 7'h40;
  endfunction : exp_mode

  function automatic logic [31:0] mg(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    for (int i = 0; i < 4; i++)
      if (s[i]) o[i*8 +: 8] = n[i*8 +: 8];
    return o;
  endfunction : mg

  function automatic void mwr(logic [7:0] a, logic [31:0] d, logic [3:0] s);
    case (a)
      `ADR_ROOT_CTRL:
        if (guest()) m_ist[4] = 1'b1;
        else
        begin
          {m_rpriv, m_rerl, m_rexl, m_gsel} = {d[5:4], d[2:0]};
          if (d[5:4] == 2'h3) m_ist[4] = 1'b1;
        end
      `ADR_GUEST_CTRL: {m_gpriv, m_gerl, m_gexl} = {d[5:4], d[2:1]};
      `ADR_ROOT_EPC:   if (guest()) m_ist[4] = 1'b1; else m_epc = mg(m_epc, d, s);
      `ADR_GUEST_EPC:  m_gepc = mg(m_gepc, d, s);
      `ADR_IRQ_CLEAR:  m_ist = m_ist & ~d[4:0];
      `ADR_IRQ_ENABLE: m_ien = d[4:0];
      default: ;
    endcase
    if (badp()) m_ist[4] = 1'b1;
  endfunction : mwr

  function automatic void mev(logic [4:0] e, logic err, logic rt, logic [31:0] pc);
    logic g0;
    g0 = guest();
    m_redir = 1'b0;
    if (e[4]) begin m_dm = 1'b1; m_debug_return_pc = pc; m_ist[3] = 1'b1; end
    else if (e[3])
    begin
      if (g0 && !rt)
        if (err) begin m_gerl = 1'b1; m_gerrpc = pc; end
        else begin if (!m_gexl) m_gepc = pc; m_gexl = 1'b1; end
      else if (err) begin m_rerl = 1'b1; m_errpc = pc; end
      else begin if (!m_rexl) m_epc = pc; m_rexl = 1'b1; end
    end
    else if (e[2]) begin if (g0) begin m_epc = pc; m_rexl = 1'b1; m_ist[2] = 1'b1; end end
    else if (e[1]) begin if (m_dm) begin m_dm = 1'b0; m_redir = 1'b1; m_tgt = m_debug_return_pc; end end
    else if (e[0] && !m_dm)
    begin
      m_redir = 1'b1;
      if (g0)
        if (m_gerl) begin m_tgt = m_gerrpc; m_gerl = 1'b0; end
        else begin m_tgt = m_gepc; m_gexl = 1'b0; end
      else if (m_rerl) begin m_tgt = m_errpc; m_rerl = 1'b0; end
      else begin m_tgt = m_epc; m_rexl = 1'b0; m_ist[0] = m_gsel; end
    end
    if (badp()) m_ist[4] = 1'b1;
    if (g0 && !guest() && !m_dm) m_ist[1] = 1'b1;
  endfunction : mev

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic cmp_mode();
    chk(mode_o, exp_mode());
    chk(guest_mode_o, guest());
    chk(root_mode_o, !guest() && !m_dm);
    chk(debug_mode_o, m_dm);
    chk($countones({guest_mode_o, root_mode_o, debug_mode_o}), 1);
    chk(bad_priv_o, badp());
  endtask : cmp_mode

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk(1'b0, 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    wb(1'b1, a, d, s);
    mwr(a, d, s);
    #1 cmp_mode();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, 4'hf);
    #1 chk(q, exp);
  endtask : rd

  task automatic ev(input logic [4:0] e, input logic err, input logic rt, input logic [31:0] pc);
    @(posedge clk_i);
    {dbg_take_i, exc_take_i, hypervisor_call_instr_i, debug_return_instr_i, exception_return_instr_i} <= e;
    exc_error_i <= err;
    exc_root_i  <= rt;
    pc_i        <= pc;
    @(posedge clk_i);
    {dbg_take_i, exc_take_i, hypervisor_call_instr_i, debug_return_instr_i, exception_return_instr_i} <= 5'h00;
    mev(e, err, rt, pc);
    #1 cmp_mode();
    chk(redirect_o, m_redir);
    if (m_redir) chk(target_o, m_tgt);
    @(posedge clk_i);
    #1 chk(redirect_o, 1'b0);
  endtask : ev

  task automatic finish_test();
    $display("checks=%0d errors=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  initial
  begin
    #50000;
    fail_count++;
    finish_test();
  end

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1 cmp_mode();
    chk(irq_o, 1'b0);
    rd(`ADR_ROOT_CTRL, 32'h4);
    rd(8'h30, 32'h0);
    wr(8'h40, 32'hffffffff);
    wr(`ADR_ROOT_CTRL, 32'h0c);
    wr(`ADR_IRQ_ENABLE, 32'h1f);
    rd(`ADR_IRQ_ENABLE, 32'h1f);
    wr(`ADR_ROOT_EPC, 32'h11223344);
    wr(`ADR_ROOT_EPC, 32'haabbccdd, 4'h3);
    rd(`ADR_ROOT_EPC, 32'h1122ccdd);
    wr(`ADR_GUEST_CTRL, 32'h20);
    wr(`ADR_ROOT_CTRL, 32'h03);
    ev(5'h01, 1'b0, 1'b0, 32'h0);
    wr(`ADR_ROOT_CTRL, 32'h00);
    wr(`ADR_ROOT_EPC, 32'h0);
    wr(`ADR_GUEST_CTRL, 32'h30);
    wr(`ADR_GUEST_CTRL, 32'h20);
    wr(`ADR_GUEST_EPC, 32'h3000);
    ev(5'h01, 1'b0, 1'b0, 32'h0);
    ev(5'h08, 1'b0, 1'b0, 32'h3100);
    ev(5'h01, 1'b0, 1'b0, 32'h0);
    ev(5'h04, 1'b0, 1'b0, 32'h2000);
    rd(`ADR_ROOT_EPC, 32'h2000);
    rd(`ADR_ROOT_CTRL, {26'h0, m_rpriv, m_dm, m_rerl, m_rexl, m_gsel});
    rd(`ADR_IRQ_STATUS, {27'h0, m_ist});
    chk(irq_o, 1'b1);
    wr(`ADR_IRQ_CLEAR, 32'h1f);
    rd(`ADR_IRQ_STATUS, 32'h0);
    chk(irq_o, 1'b0);
    ev(5'h01, 1'b0, 1'b0, 32'h0);
    ev(5'h08, 1'b1, 1'b1, 32'h4000);
    ev(5'h01, 1'b0, 1'b0, 32'h0);
    ev(5'h10, 1'b0, 1'b0, 32'h5000);
    ev(5'h01, 1'b0, 1'b0, 32'h0);
    ev(5'h02, 1'b0, 1'b0, 32'h0);
    wr(`ADR_IRQ_CLEAR, 32'h1f);
    wr(`ADR_IRQ_ENABLE, 32'h08);
    ev(5'h04, 1'b0, 1'b0, 32'h6000);
    chk(irq_o, 1'b0);
    rd(`ADR_IRQ_STATUS, 32'h06);
    wr(`ADR_IRQ_ENABLE, 32'h04);
    chk(irq_o, 1'b1);
    wr(`ADR_IRQ_CLEAR, 32'h04);
    chk(irq_o, 1'b0);
    wr(`ADR_ROOT_CTRL, 32'h30);
    wr(`ADR_ROOT_CTRL, 32'h10);
    wr(`ADR_IRQ_CLEAR, 32'h1f);
    // Clock enable low freezes state
    @(posedge clk_i);
    ce_i   <= 1'b0;
    exception_return_instr_i <= 1'b1;
    @(posedge clk_i);
    exception_return_instr_i <= 1'b0;
    ce_i   <= 1'b1;
    #1 cmp_mode();
    chk(redirect_o, 1'b0);
    repeat (300)
    begin
      r = rnd();
      case (r[2:0])
        3'h0: wr(`ADR_ROOT_CTRL, {26'h0, (r[5:4] == 2'h3) ? 2'h2 : r[5:4], 1'b0, r[10:8]});
        3'h1: wr(`ADR_GUEST_CTRL, {26'h0, (r[5:4] == 2'h3) ? 2'h2 : r[5:4], 1'b0, r[10:9], 1'b0});
        3'h2: ev(5'h08, r[11], r[12], rnd());
        3'h3, 3'h4: ev(5'h01, r[11], r[12], rnd());
        3'h5: ev(5'h04, r[11], r[12], rnd());
        3'h6: ev(5'h02, r[11], r[12], rnd());
        default: wr(r[13] ? `ADR_ROOT_EPC : `ADR_GUEST_EPC, rnd());
      endcase
    end
    wr(`ADR_IRQ_CLEAR, 32'h1f);
    rd(`ADR_IRQ_STATUS, 32'h0);
    finish_test();
  end
endmodule : testbench
